// file: common/hpmc_pkg.sv
// Shared constants for the host port mode and pin control block
package hpmc_pkg;
    // ----------------------------------------
    // Widths and sizes
    // ----------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int NUM_SUB = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int SEL_W = 2;
    localparam int AREG_W = 16;

    // ----------------------------------------
    // Multiplexed mode access types on the low address pins
    // ----------------------------------------
    localparam logic [1:0] ACC_CONTROL = 2'h0;
    localparam logic [1:0] ACC_DATA_INC = 2'h1;
    localparam logic [1:0] ACC_ADDRESS = 2'h2;
    localparam logic [1:0] ACC_DATA = 2'h3;

    // ----------------------------------------
    // Control register fields and reset values
    // ----------------------------------------
    localparam int CTRL_DSPINT_BIT = 1;
    localparam int CTRL_HOST_INTERRUPT_BIT = 3;
    localparam logic [15:0] AREG_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [18:0] ADDR_RESET = 19'h00000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_READ,
        ST_HOLD
    } hpmc_state_type;
endpackage : hpmc_pkg

// file: hdl/hpmc_fifo.sv
// Parameterised valid/ready FIFO for host port memory commands
`timescale 1ns/1ps
module hpmc_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = hpmc_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W:0] count;

    wire push = inValid & inReady;
    wire pop = outValid & outReady;

    // Honest flags: full stalls the filling side
    assign inReady = (count != DEPTH_CNT);
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == LAST_PTR) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == LAST_PTR) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
        end
    end

    fifo_bound_a: assert property (@(posedge clk_sys) disable iff (rst) count <= DEPTH_CNT)
        else $error("fifo count beyond depth");
endmodule : hpmc_fifo

// file: hdl/hpmc_port.sv
// Host port pin control: mode select, register access, keepers, test tristate
`timescale 1ns/1ps
// Function
// - Mode pin low selects multiplexed register access
// - Multiplexed mode supports interrupts both directions
// - Mode pin high selects separate-bus mode
// - Separate-bus mode decodes full 19-bit address
// - Address top bit selects program or data
// - Address keepers hold last driven level
// - Address keepers cleared by either reset
// - Data keepers hold last driven level
// - Data keepers cleared by either reset
// - Off pin low tristates data and ready
// - No interrupts in separate-bus mode
// - Ready driven when selected, else high impedance
// - Host interrupt low; host writes one clears
module hpmc_port #(
    parameter int ADDR_W = hpmc_pkg::ADDR_W,
    parameter int DATA_W = hpmc_pkg::DATA_W,
    parameter int NUM_SUB = hpmc_pkg::NUM_SUB,
    parameter int FIFO_DEPTH = hpmc_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic portModeSelect,
    input wire logic [ADDR_W-1:0] hostAddressIn,
    input wire logic hostAddressDriven,
    output logic [ADDR_W-1:0] hostAddressOut,
    output logic hostAddressOe_n,
    input wire logic [DATA_W-1:0] hostDataIn,
    input wire logic hostDataDriven,
    output logic [DATA_W-1:0] hostDataOut,
    output logic hostDataOe_n,
    input wire logic portChipSelect_n,
    input wire logic hostDataStrobe_n,
    input wire logic hostReadWrite,
    input wire logic [hpmc_pkg::SEL_W-1:0] subsystemSelect,
    output logic portReadyOut,
    output logic portReadyOe_n,
    input wire logic emulationOffMode,
    input wire logic emulationOffPin,
    input wire logic subsystemReset,
    input wire logic keeperWrite,
    input wire logic addressKeeperEnableIn,
    input wire logic dataKeeperEnableIn,
    output logic addressKeeperEnable,
    output logic dataKeeperEnable,
    input wire logic [NUM_SUB-1:0] dspToHostIrq,
    output logic [NUM_SUB-1:0] hostInterrupt_n,
    output logic [NUM_SUB-1:0] hostInterruptOe_n,
    output logic [NUM_SUB-1:0] hostToDspIrq,
    output logic memReqValid,
    input wire logic memReqReady,
    output logic memReqWrite,
    output logic memReqProgram,
    output logic [ADDR_W-1:0] memReqAddr,
    output logic [DATA_W-1:0] memReqData,
    input wire logic memRdValid,
    input wire logic [DATA_W-1:0] memRdData
);
    localparam int CMD_W = 1 + ADDR_W + DATA_W;

    // ----------------------------------------
    // Strobe decode
    // ----------------------------------------
    hpmc_pkg::hpmc_state_type state;
    hpmc_pkg::hpmc_state_type next_state;
    logic strobePrev;
    logic [15:0] addrReg;
    logic [DATA_W-1:0] readData;
    logic readValid;
    logic [ADDR_W-1:0] lastAddr;
    logic [DATA_W-1:0] lastData;
    logic [NUM_SUB-1:0] hostIntFlag;
    logic fifoInReady;
    logic [CMD_W-1:0] fifoOut;

    wire strobeActive = ~portChipSelect_n & ~hostDataStrobe_n;
    wire strobeRise = strobeActive & ~strobePrev;
    wire muxMode = ~portModeSelect;
    wire [1:0] accessType = hostAddressIn[1:0];
    // separate-bus hosts use data path only
    wire isMemAccess = portModeSelect | accessType[0];
    wire isCtrlAccess = muxMode & (accessType == hpmc_pkg::ACC_CONTROL);
    wire isAddrAccess = muxMode & (accessType == hpmc_pkg::ACC_ADDRESS);
    wire canAccept = (state == hpmc_pkg::ST_IDLE) & (fifoInReady | ~isMemAccess);
    wire accept = strobeRise & canAccept;
    wire fifoPush = accept & isMemAccess;
    wire ctrlWrite = accept & isCtrlAccess & ~hostReadWrite;
    wire addrWrite = accept & isAddrAccess & ~hostReadWrite;
    wire autoInc = accept & muxMode & (accessType == hpmc_pkg::ACC_DATA_INC);
    // in separate-bus mode all 19 pins form the address, else the 16-bit address register
    wire [ADDR_W-1:0] pushAddr = portModeSelect ? hostAddressIn : ADDR_W'(addrReg);
    wire [CMD_W-1:0] pushCmd = {~hostReadWrite, pushAddr, hostDataIn};
    wire offActive = emulationOffMode & ~emulationOffPin;
    wire [NUM_SUB-1:0] selOneHot = NUM_SUB'(1) << subsystemSelect;
    wire [DATA_W-1:0] ctrlReadValue = DATA_W'(|(hostIntFlag & selOneHot)) << hpmc_pkg::CTRL_HOST_INTERRUPT_BIT;
    wire [DATA_W-1:0] regReadValue = isCtrlAccess ? ctrlReadValue : DATA_W'(addrReg);

    // ----------------------------------------
    // Transfer sequencing
    // ----------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            hpmc_pkg::ST_IDLE: begin
                if (accept) begin
                    next_state = (isMemAccess & hostReadWrite) ? hpmc_pkg::ST_WAIT_READ : hpmc_pkg::ST_HOLD;
                end
            end
            hpmc_pkg::ST_WAIT_READ: begin
                if (memRdValid) begin
                    next_state = hpmc_pkg::ST_HOLD;
                end
            end
            hpmc_pkg::ST_HOLD: begin
                if (!strobeActive) begin
                    next_state = hpmc_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= hpmc_pkg::ST_IDLE;
            strobePrev <= 1'b0;
        end else begin
            state <= next_state;
            strobePrev <= strobeActive;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            addrReg <= hpmc_pkg::AREG_RESET;
        end else if (addrWrite) begin
            addrReg <= hostDataIn;
        end else if (autoInc) begin
            addrReg <= addrReg + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            readData <= hpmc_pkg::DATA_RESET;
            readValid <= 1'b0;
        end else if (accept & ~isMemAccess & hostReadWrite) begin
            readData <= regReadValue;
            readValid <= 1'b1;
        end else if (state == hpmc_pkg::ST_WAIT_READ && memRdValid) begin
            readData <= memRdData;
            readValid <= 1'b1;
        end else if (state == hpmc_pkg::ST_HOLD && !strobeActive) begin
            readValid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Command buffer toward memory
    // ----------------------------------------
    // Writes and reads share one queue so a read never overtakes a write
    hpmc_fifo #(
        .WIDTH(CMD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .inValid(fifoPush),
        .inReady(fifoInReady),
        .inData(pushCmd),
        .outValid(memReqValid),
        .outReady(memReqReady),
        .outData(fifoOut)
    );

    assign memReqWrite = fifoOut[CMD_W-1];
    assign memReqAddr = fifoOut[CMD_W-2:DATA_W];
    assign memReqData = fifoOut[DATA_W-1:0];
    // top address bit picks program memory
    assign memReqProgram = fifoOut[CMD_W-2];

    // ----------------------------------------
    // Ready pin
    // ----------------------------------------
    // ready only while selected
    assign portReadyOut = (state == hpmc_pkg::ST_IDLE) & fifoInReady;
    assign portReadyOe_n = portChipSelect_n | offActive;

    // ----------------------------------------
    // Keepers
    // ----------------------------------------
    // both resets disable keepers
    always_ff @(posedge clk_sys) begin
        if (rst || subsystemReset) begin
            addressKeeperEnable <= 1'b0;
            dataKeeperEnable <= 1'b0;
        end else if (keeperWrite) begin
            addressKeeperEnable <= addressKeeperEnableIn;
            dataKeeperEnable <= dataKeeperEnableIn;
        end
    end

    wire driveData = readValid & strobeActive & hostReadWrite & ~offActive;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lastAddr <= hpmc_pkg::ADDR_RESET;
            lastData <= hpmc_pkg::DATA_RESET;
        end else begin
            if (hostAddressDriven) begin
                lastAddr <= hostAddressIn;
            end
            if (driveData) begin
                lastData <= readData;
            end else if (hostDataDriven) begin
                lastData <= hostDataIn;
            end
        end
    end

    assign hostAddressOut = lastAddr;
    assign hostAddressOe_n = ~(addressKeeperEnable & ~hostAddressDriven);
    assign hostDataOut = driveData ? readData : lastData;
    wire dataKeep = dataKeeperEnable & ~hostDataDriven & ~driveData;
    assign hostDataOe_n = ~((driveData | dataKeep) & ~offActive);

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // only multiplexed mode raises either direction
    wire [NUM_SUB-1:0] intSet = dspToHostIrq & {NUM_SUB{muxMode}};
    wire [NUM_SUB-1:0] intClear = selOneHot & {NUM_SUB{ctrlWrite & hostDataIn[hpmc_pkg::CTRL_HOST_INTERRUPT_BIT]}};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hostIntFlag <= '0;
            hostToDspIrq <= '0;
        end else begin
            // A new event beats a clear in the same cycle
            hostIntFlag <= intSet | (hostIntFlag & ~intClear);
            hostToDspIrq <= selOneHot & {NUM_SUB{ctrlWrite & hostDataIn[hpmc_pkg::CTRL_DSPINT_BIT]}};
        end
    end

    assign hostInterrupt_n = ~hostIntFlag;
    assign hostInterruptOe_n = {NUM_SUB{portModeSelect | offActive}};

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    mux_addr_write_a: assert property (addrWrite |=> addrReg == $past(hostDataIn))
        else $error("address register not loaded");
    host_interrupt_raise_a: assert property (intSet[0] |=> !hostInterrupt_n[0])
        else $error("host interrupt not raised");
    nonmux_no_reg_a: assert property (portModeSelect && accept |-> fifoPush)
        else $error("separate-bus access missed data path");
    full_addr_a: assert property (fifoPush && portModeSelect |-> pushCmd[CMD_W-2:DATA_W] == hostAddressIn)
        else $error("address bits lost");
    mem_select_a: assert property (memReqValid |-> memReqProgram == memReqAddr[ADDR_W-1])
        else $error("memory select wrong");
    addr_keeper_a: assert property (hostAddressDriven ##1 (!hostAddressDriven && addressKeeperEnable)
        |-> !hostAddressOe_n && hostAddressOut == $past(hostAddressIn))
        else $error("address keeper lost level");
    addr_keep_reset_a: assert property (subsystemReset |=> !addressKeeperEnable)
        else $error("address keeper survived reset");
    data_keeper_a: assert property (hostDataDriven ##1 (dataKeep && !offActive)
        |-> !hostDataOe_n && hostDataOut == $past(hostDataIn))
        else $error("data keeper lost level");
    data_keep_reset_a: assert property (subsystemReset |=> !dataKeeperEnable)
        else $error("data keeper survived reset");
    off_float_a: assert property (offActive |-> hostDataOe_n && portReadyOe_n && (&hostInterruptOe_n))
        else $error("pins driven while off");
    nonmux_quiet_a: assert property (portModeSelect |=> hostToDspIrq == '0
        && (hostIntFlag & ~$past(hostIntFlag)) == '0)
        else $error("interrupt in separate-bus mode");
    ready_float_a: assert property (portChipSelect_n |-> portReadyOe_n)
        else $error("ready driven while unselected");
    host_interrupt_clear_a: assert property (intClear[0] && !intSet[0] |=> hostInterrupt_n[0])
        else $error("host interrupt not cleared");
    read_drive_a: assert property (driveData |-> hostReadWrite && strobeActive && !hostDataOe_n
        && hostDataOut == readData)
        else $error("data bus driven outside read");

    mux_read_c: cover property (accept && muxMode && hostReadWrite ##[1:20] driveData);
    nonmux_write_c: cover property (fifoPush && portModeSelect && !hostReadWrite);
    fifo_full_c: cover property (!fifoInReady ##1 fifoInReady);
    host_interrupt_cycle_c: cover property (intSet[0] ##[1:50] intClear[0]);
endmodule : hpmc_port

// file: testbench/hpmc_host_model.sv
// Host processor model driving the host port pins
`timescale 1ns/1ps
module hpmc_host_model (
    input wire logic clk_sys,
    input wire logic [15:0] pinData,
    input wire logic pinDataOe_n,
    output logic [18:0] addr,
    output logic addrDriven,
    output logic [15:0] data,
    output logic dataDriven,
    output logic chipSelect_n,
    output logic strobe_n,
    output logic readWrite
);
    initial begin
        {addr, data} = 35'h0;
        {addrDriven, dataDriven} = 2'b00;
        {chipSelect_n, strobe_n, readWrite} = 3'b111;
    end

    task automatic xfer(input logic r, input logic [18:0] a, input logic [15:0] d, output logic [15:0] q,
        output logic ok);
        int n;
        @(negedge clk_sys);
        {chipSelect_n, readWrite, addr, addrDriven} = {1'b0, r, a, 1'b1};
        {data, dataDriven, strobe_n} = {r ? ~d : d, !r, 1'b0};
        n = 0;
        if (r) begin
            // Slow answers from memory are waited for, within a bound
            while (pinDataOe_n !== 1'b0 && n < 40) begin
                @(negedge clk_sys);
                n++;
            end
        end else begin
            repeat (2) @(negedge clk_sys);
        end
        ok = (pinDataOe_n === 1'b0);
        q = pinData;
        // Released lines show the inverse, never a stale copy
        {strobe_n, addrDriven, addr, dataDriven, data} = {1'b1, 1'b0, ~a, 1'b0, ~data};
        @(negedge clk_sys);
    endtask : xfer

    task automatic deselect;
        @(negedge clk_sys);
        chipSelect_n = 1'b1;
    endtask : deselect
endmodule : hpmc_host_model

// file: testbench/hpmc_port_bench.sv
// Self-checking bench for the host port pin control block
`timescale 1ns/1ps
`define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin errors++; $display("mismatch at %0t: %s", $time, m); end end
module hpmc_port_bench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic portModeSelect = 1'b1;
    logic emulationOffMode = 1'b0;
    logic emulationOffPin = 1'b1;
    logic subsystemReset = 1'b0;
    logic keeperWrite = 1'b0;
    logic addressKeeperEnableIn = 1'b0;
    logic dataKeeperEnableIn = 1'b0;
    logic [1:0] subsystemSelect = 2'h0;
    logic [3:0] dspToHostIrq = 4'h0;
    logic [3:0] pulseSeen = 4'h0;
    logic memReqReady = 1'b0;
    logic memRdValid = 1'b0;
    logic stall = 1'b0;
    logic rdPend = 1'b0;
    logic [15:0] memRdData = 16'h0000;
    logic [18:0] hAddr, hostAddressOut, memReqAddr, rdAddr;
    logic [15:0] hData, hostDataOut, memReqData, q;
    logic hAddrDrv, hDataDrv, csN, dsN, rw, ok, offWatch;
    logic hostAddressOe_n, hostDataOe_n, portReadyOut, portReadyOe_n, addressKeeperEnable, dataKeeperEnable;
    logic memReqValid, memReqWrite, memReqProgram;
    logic [3:0] hostInterrupt_n, hostInterruptOe_n, hostToDspIrq;
    logic [36:0] expQ[$];
    int errors = 0;
    int comparisons = 0;
    int got = 0;
    int offBad = 0;
    int seed = 32'hc8c0876e;

    always #2 clk_sys = ~clk_sys;

    hpmc_host_model host (.clk_sys(clk_sys), .pinData(hostDataOut), .pinDataOe_n(hostDataOe_n), .addr(hAddr),
        .addrDriven(hAddrDrv), .data(hData), .dataDriven(hDataDrv), .chipSelect_n(csN), .strobe_n(dsN),
        .readWrite(rw));

    hpmc_port dut (.clk_sys(clk_sys), .rst(rst), .portModeSelect(portModeSelect),
        .hostAddressIn(hAddrDrv | hostAddressOe_n ? hAddr : hostAddressOut), .hostAddressDriven(hAddrDrv),
        .hostAddressOut(hostAddressOut), .hostAddressOe_n(hostAddressOe_n),
        .hostDataIn(hDataDrv | hostDataOe_n ? hData : hostDataOut), .hostDataDriven(hDataDrv),
        .hostDataOut(hostDataOut), .hostDataOe_n(hostDataOe_n), .portChipSelect_n(csN), .hostDataStrobe_n(dsN),
        .hostReadWrite(rw), .subsystemSelect(subsystemSelect), .portReadyOut(portReadyOut),
        .portReadyOe_n(portReadyOe_n), .emulationOffMode(emulationOffMode), .emulationOffPin(emulationOffPin),
        .subsystemReset(subsystemReset), .keeperWrite(keeperWrite), .addressKeeperEnableIn(addressKeeperEnableIn),
        .dataKeeperEnableIn(dataKeeperEnableIn), .addressKeeperEnable(addressKeeperEnable),
        .dataKeeperEnable(dataKeeperEnable), .dspToHostIrq(dspToHostIrq), .hostInterrupt_n(hostInterrupt_n),
        .hostInterruptOe_n(hostInterruptOe_n), .hostToDspIrq(hostToDspIrq), .memReqValid(memReqValid),
        .memReqReady(memReqReady), .memReqWrite(memReqWrite), .memReqProgram(memReqProgram),
        .memReqAddr(memReqAddr), .memReqData(memReqData), .memRdValid(memRdValid), .memRdData(memRdData));

    // ----------------------------------------
    // Memory side: random stalls, one-cycle read answers
    // ----------------------------------------
    always @(negedge clk_sys) begin
        memRdValid = rdPend;
        memRdData = rdAddr[15:0] ^ 16'h5a3c;
        rdPend = 1'b0;
        memReqReady = !stall && ($random(seed) % 4 != 0);
    end

    always @(posedge clk_sys) begin
        if (!rst && memReqValid === 1'b1 && memReqReady) begin
            got++;
            if (expQ.size() == 0) `CHK(1'b1, 1'b0, "unexpected request")
            else `CHK({memReqWrite, memReqProgram, memReqAddr, memReqWrite ? memReqData : 16'h0}, expQ.pop_front(), "request")
            rdPend = !memReqWrite;
            rdAddr = memReqAddr;
        end
        pulseSeen = pulseSeen | hostToDspIrq;
        if (offWatch && (hostDataOe_n !== 1'b1 || portReadyOe_n !== 1'b1)) offBad++;
    end

    // ----------------------------------------
    // Transfers and closing report
    // ----------------------------------------
    task automatic sepWr(input logic [18:0] a, input logic [15:0] d);
        expQ.push_back({1'b1, a[18], a, d});
        host.xfer(1'b0, a, d, q, ok);
    endtask : sepWr

    task automatic sepRd(input logic [18:0] a);
        expQ.push_back({1'b0, a[18], a, 16'h0});
        host.xfer(1'b1, a, 16'h0, q, ok);
        `CHK({ok, q}, {1'b1, a[15:0] ^ 16'h5a3c}, "read data")
    endtask : sepRd

    task automatic muxAcc(input logic r, input logic [1:0] t, input logic [15:0] d);
        host.xfer(r, {17'h0, t}, d, q, ok);
    endtask : muxAcc

    task automatic drain;
        int n;
        n = 0;
        while (expQ.size() != 0 && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        `CHK(expQ.size(), 0, "requests lost")
        repeat (4) @(negedge clk_sys);
    endtask : drain

    task automatic results;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results

    initial begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        results();
    end

    initial begin
        logic [18:0] a;
        logic [15:0] d;
        logic [18:0] corner [4];
        corner = '{19'h00000, 19'h3ffff, 19'h40000, 19'h7ffff};
        offWatch = 1'b0;
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        `CHK({addressKeeperEnable, dataKeeperEnable, hostAddressOe_n}, 3'b001, "keepers at reset")
        `CHK({hostInterrupt_n, portReadyOe_n}, 5'h1f, "pins at reset")
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            a = (i < 4) ? corner[i] : 19'($random(seed));
            sepWr(a, 16'($random(seed)));
            if (i % 2 == 0 || i < 4) sepRd(a);
        end
        `CHK({portReadyOe_n, portReadyOut, hostDataOe_n}, 3'b011, "ready or data pins idle")
        drain();
        $display("test separate done");
        {keeperWrite, addressKeeperEnableIn, dataKeeperEnableIn} = 3'b111;
        @(negedge clk_sys);
        keeperWrite = 1'b0;
        a = 19'($random(seed));
        d = 16'($random(seed));
        sepWr(a, d);
        drain();
        `CHK({hostAddressOe_n, hostAddressOut}, {1'b0, a}, "address keeper")
        `CHK({hostDataOe_n, hostDataOut}, {1'b0, d}, "data keeper")
        subsystemReset = 1'b1;
        @(negedge clk_sys);
        {subsystemReset, keeperWrite} = 2'b01;
        `CHK({addressKeeperEnable, dataKeeperEnable, hostAddressOe_n, hostDataOe_n}, 4'h3, "subsystem reset")
        @(negedge clk_sys);
        {keeperWrite, rst} = 2'b01;
        @(negedge clk_sys);
        rst = 1'b0;
        `CHK({addressKeeperEnable, dataKeeperEnable, hostAddressOe_n, hostDataOe_n}, 4'h3, "global reset")
        $display("test keepers done");
        {emulationOffMode, emulationOffPin, offWatch} = 3'b101;
        expQ.push_back({1'b0, 1'b0, 19'h12345, 16'h0});
        host.xfer(1'b1, 19'h12345, 16'h0, q, ok);
        {emulationOffMode, emulationOffPin, offWatch} = 3'b010;
        `CHK({ok, offBad}, 33'h0, "pins driven while off")
        drain();
        sepRd(19'h12345);
        drain();
        $display("test off done");
        portModeSelect = 1'b0;
        d = 16'($random(seed));
        muxAcc(1'b0, hpmc_pkg::ACC_ADDRESS, d);
        muxAcc(1'b1, hpmc_pkg::ACC_ADDRESS, 16'h0);
        `CHK({ok, q}, {1'b1, d}, "address register")
        expQ.push_back({2'b10, {3'b000, d}, 16'h1111});
        muxAcc(1'b0, hpmc_pkg::ACC_DATA_INC, 16'h1111);
        expQ.push_back({2'b10, {3'b000, d + 16'h0001}, 16'h2222});
        muxAcc(1'b0, hpmc_pkg::ACC_DATA, 16'h2222);
        expQ.push_back({2'b00, {3'b000, d + 16'h0001}, 16'h0});
        muxAcc(1'b1, hpmc_pkg::ACC_DATA, 16'h0);
        `CHK({ok, q}, {1'b1, (d + 16'h0001) ^ 16'h5a3c}, "mux memory read")
        drain();
        for (int i = 0; i < 4; i++) begin
            subsystemSelect = 2'(i);
            dspToHostIrq[i] = 1'b1;
            repeat (3) @(negedge clk_sys);
            dspToHostIrq = 4'h0;
            `CHK(hostInterrupt_n[i] | hostInterruptOe_n[i], 1'b0, "interrupt not raised")
            muxAcc(1'b1, hpmc_pkg::ACC_CONTROL, 16'h0);
            `CHK({ok, q[hpmc_pkg::CTRL_HOST_INTERRUPT_BIT]}, 2'b11, "interrupt flag")
            pulseSeen = 4'h0;
            muxAcc(1'b0, hpmc_pkg::ACC_CONTROL, 16'h000a);
            `CHK({hostInterrupt_n[i], pulseSeen}, {1'b1, 4'h1 << i}, "clear or pulse")
        end
        portModeSelect = 1'b1;
        dspToHostIrq = 4'hf;
        repeat (3) @(negedge clk_sys);
        `CHK({hostInterruptOe_n, hostInterrupt_n}, 8'hff, "interrupt in separate mode")
        dspToHostIrq = 4'h0;
        $display("test mux done");
        stall = 1'b1;
        repeat (2) @(negedge clk_sys);
        got = 0;
        for (int i = 0; i < 9; i++) begin
            a = 19'($random(seed));
            if (i < 8) sepWr(a, 16'($random(seed)));
            else begin
                `CHK(portReadyOut, 1'b0, "ready while full")
                host.xfer(1'b0, a, 16'h0, q, ok);
            end
        end
        stall = 1'b0;
        drain();
        `CHK(got, 8, "refused write")
        host.deselect();
        @(negedge clk_sys);
        `CHK(portReadyOe_n, 1'b1, "ready driven while deselected")
        $display("test fill done");
        results();
    end
endmodule : hpmc_port_bench
